// ===== design/ssp_ir_config.sv
// ssp_ir_config: configuration and infrared line steering of the second
// serial port: mode flags, polarity, duplex, encoding, pin routing, blanking
// assumes a uart core on the inside and a line driver or ir transceiver
// outside; all inputs are synchronous to MCLK_I
//
// Design decision made here: strobed register access.
module ssp_ir_config
  import ssp_pkg::*;
(
  input  wire logic       MCLK_I,
  input  wire logic       NRST_I,
  input  wire logic [7:0] CFG_ADDR_I,
  input  wire logic [7:0] CFG_WDATA_I,
  input  wire logic       CFG_WR_I,
  input  wire logic       CFG_RD_I,
  output logic      [7:0] CFG_RDATA_O,
  input  wire logic       UART_TX_I,
  output logic            UART_RX_O,
  input  wire logic       SECOND_PORT_RECEIVE_PIN_I,
  output logic            SECOND_PORT_TRANSMIT_PIN_O,
  input  wire logic       ALTERNATE_INFRARED_RECEIVE_PIN_I,
  output logic            ALTERNATE_INFRARED_TRANSMIT_PIN_O,
  output logic            MIDI_EN_O,
  output logic            HIGH_SPEED_O,
  output logic      [2:0] IR_ENCODING_O,
  output logic            HALF_DUPLEX_O
);

  ssp_port_mode_s port_mode;
  ssp_ir_option_s ir_option;
  logic     [7:0] hd_timeout;
  ssp_status_s    status;

  logic     [7:0] next_rdata;
  logic           enc_reserved;
  logic           ir_active;
  logic           rx_sel;
  logic           rx_norm;
  logic           tx_act;
  logic           rx_act;
  logic           tx_timer_blank;
  logic           rx_timer_blank;
  logic           tx_blank;
  logic           rx_blank;
  logic           next_uart_rx;
  logic           tx_line;
  logic           next_tx_pin;
  logic           tx_idle_pin;

  // index match for a strobe
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    hit = (addr == idx);
  endfunction

  // polarity only bends the line in the infrared encodings, so a plain
  // serial port keeps its usual idle-high sense whatever the option says
  function automatic logic bend(input logic v, input logic ir, input logic low);
    bend = v ^ (ir & ~low);
  endfunction

  function automatic logic is_reserved_enc(input logic [2:0] enc);
    is_reserved_enc = (enc != ENC_STANDARD) && (enc != ENC_IRDA) && (enc != ENC_ASK);
  endfunction

  // ---- register writes ----

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      port_mode <= RST_PORT_MODE;
    end else if (CFG_WR_I && hit(CFG_ADDR_I, IDX_PORT_MODE)) begin
      // reserved bits are not stored, so a stray one from software is harmless
      port_mode <= CFG_WDATA_I & PORT_MODE_WMASK;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ir_option <= RST_IR_OPTION;
    end else if (CFG_WR_I && hit(CFG_ADDR_I, IDX_IR_OPTION)) begin
      ir_option <= CFG_WDATA_I & IR_OPTION_WMASK;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hd_timeout <= RST_HD_TIMEOUT;
    end else if (CFG_WR_I && hit(CFG_ADDR_I, IDX_HD_TIMEOUT)) begin
      hd_timeout <= CFG_WDATA_I;
    end
  end

  // ---- register reads ----

  always_comb begin
    status              = '0;
    status.tx_blank     = tx_blank;
    status.rx_blank     = rx_blank;
    status.enc_reserved = enc_reserved;
    status.rx_line      = rx_norm;
  end

  always_comb begin
    next_rdata = READ_NONE;
    if (CFG_RD_I) begin
      case (CFG_ADDR_I)
        IDX_PORT_MODE:  next_rdata = port_mode;
        IDX_IR_OPTION:  next_rdata = ir_option;
        IDX_HD_TIMEOUT: next_rdata = hd_timeout;
        IDX_STATUS:     next_rdata = status;
        default:        next_rdata = READ_NONE;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CFG_RDATA_O <= READ_NONE;
    end else begin
      CFG_RDATA_O <= next_rdata;
    end
  end

  // ---- mode flags towards the uart core ----

  assign MIDI_EN_O    = port_mode.midi;
  assign HIGH_SPEED_O = port_mode.high_speed;

  assign enc_reserved = is_reserved_enc(ir_option.encoding);
  assign ir_active    = (ir_option.encoding == ENC_IRDA) ||
                        (ir_option.encoding == ENC_ASK);

  // reserved codes are not passed on; the core then runs as a plain port
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IR_ENCODING_O <= ENC_STANDARD;
    end else if (enc_reserved) begin
      IR_ENCODING_O <= ENC_STANDARD;
    end else begin
      IR_ENCODING_O <= ir_option.encoding;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      HALF_DUPLEX_O <= 1'b0;
    end else begin
      HALF_DUPLEX_O <= ir_option.half_duplex;
    end
  end

  // ---- receive path ----

  assign rx_sel = ir_option.alt_pins ? ALTERNATE_INFRARED_RECEIVE_PIN_I
                                     : SECOND_PORT_RECEIVE_PIN_I;

  assign rx_norm = bend(rx_sel, ir_active, ir_option.rx_active_low);

  // a start bit or space on the line counts as receive activity
  assign rx_act = ir_option.half_duplex && !rx_norm && !rx_blank && !tx_act;

  assign next_uart_rx = rx_blank ? LINE_IDLE : rx_norm;

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      UART_RX_O <= LINE_IDLE;
    end else begin
      UART_RX_O <= next_uart_rx;
    end
  end

  // ---- transmit path ----

  // transmit wins a tie: a receive start in the same cycle is not counted
  assign tx_act = ir_option.half_duplex && !UART_TX_I && !tx_blank;

  assign tx_line     = tx_blank ? LINE_IDLE : UART_TX_I;
  assign next_tx_pin = bend(tx_line, ir_active, ir_option.tx_active_low);
  assign tx_idle_pin = bend(LINE_IDLE, ir_active, ir_option.tx_active_low);

  // the pin pair not in use rests at idle so the far side sees no noise
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SECOND_PORT_TRANSMIT_PIN_O <= LINE_IDLE;
    end else if (ir_option.alt_pins) begin
      SECOND_PORT_TRANSMIT_PIN_O <= tx_idle_pin;
    end else begin
      SECOND_PORT_TRANSMIT_PIN_O <= next_tx_pin;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ALTERNATE_INFRARED_TRANSMIT_PIN_O <= LINE_IDLE;
    end else if (ir_option.alt_pins) begin
      ALTERNATE_INFRARED_TRANSMIT_PIN_O <= next_tx_pin;
    end else begin
      ALTERNATE_INFRARED_TRANSMIT_PIN_O <= tx_idle_pin;
    end
  end

  // ---- half duplex blanking ----

  // transmit activity blanks the receiver and the other way round;
  // each timer stretches its window by the programmed count of steps
  ssp_blank_timer u_tx_timer (
    .clk_i    (MCLK_I),
    .rst_n_i  (NRST_I),
    .active_i (tx_act),
    .count_i  (hd_timeout),
    .blank_o  (tx_timer_blank)
  );

  ssp_blank_timer u_rx_timer (
    .clk_i    (MCLK_I),
    .rst_n_i  (NRST_I),
    .active_i (rx_act),
    .count_i  (hd_timeout),
    .blank_o  (rx_timer_blank)
  );

  // leaving half duplex drops any window at once
  assign rx_blank = ir_option.half_duplex && tx_timer_blank;
  assign tx_blank = ir_option.half_duplex && rx_timer_blank;

endmodule

// ===== design/ssp_pkg.sv
// ssp_pkg: constants and types of the second serial port infrared config block
// assumes a 10 MHz core clock and an 8-bit configuration index space
package ssp_pkg;

  // blanking step and core clock rate
  localparam int unsigned CLK_KHZ        = 10000;
  localparam int unsigned STEP_US        = 100;
  localparam int unsigned MAX_TIMEOUT_MS = 10;
  localparam int unsigned STEP_CYCLES    = (STEP_US * CLK_KHZ + 999) / 1000;
  localparam logic [9:0]  STEP_LAST      = 10'(STEP_CYCLES - 1);

  // configuration indexes
  localparam logic [7:0] IDX_PORT_MODE  = 8'hf0;
  localparam logic [7:0] IDX_IR_OPTION  = 8'hf1;
  localparam logic [7:0] IDX_HD_TIMEOUT = 8'hf2;
  localparam logic [7:0] IDX_STATUS     = 8'hf3;

  // reset values
  localparam logic [7:0] RST_PORT_MODE  = 8'h00;
  localparam logic [7:0] RST_IR_OPTION  = 8'h02;
  localparam logic [7:0] RST_HD_TIMEOUT = 8'h03;

  // bits that store; reserved bits read as zero
  localparam logic [7:0] PORT_MODE_WMASK = 8'h03;
  localparam logic [7:0] IR_OPTION_WMASK = 8'h7f;
  localparam logic [7:0] READ_NONE       = 8'h00;

  localparam logic       LINE_IDLE  = 1'b1;
  localparam logic [7:0] STEPS_NONE = 8'h00;
  localparam logic [7:0] STEP_ONE   = 8'h01;
  localparam logic [9:0] PRE_ZERO   = 10'h000;
  localparam logic [9:0] PRE_ONE    = 10'h001;

  // port encodings
  localparam logic [2:0] ENC_STANDARD = 3'h0;
  localparam logic [2:0] ENC_IRDA     = 3'h1;
  localparam logic [2:0] ENC_ASK      = 3'h2;

  typedef struct packed {
    logic [5:0] reserved;
    logic       high_speed;
    logic       midi;
  } ssp_port_mode_s;

  typedef struct packed {
    logic       reserved;
    logic       alt_pins;
    logic [2:0] encoding;
    logic       half_duplex;
    logic       tx_active_low;
    logic       rx_active_low;
  } ssp_ir_option_s;

  typedef struct packed {
    logic [3:0] zero;
    logic       rx_line;
    logic       enc_reserved;
    logic       rx_blank;
    logic       tx_blank;
  } ssp_status_s;

  typedef enum logic [1:0] {
    TMR_IDLE   = 2'b00,
    TMR_ACTIVE = 2'b01,
    TMR_HOLD   = 2'b11
  } ssp_tmr_e;

endpackage

// ===== design/ssp_blank_timer.sv
// ssp_blank_timer: holds a blanking window while a direction is active
// and for a programmed number of 100 us steps after it goes quiet
// assumes active_i is synchronous to clk_i
module ssp_blank_timer
  import ssp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       active_i,
  input  wire logic [7:0] count_i,
  output logic            blank_o
);

  ssp_tmr_e   state;
  ssp_tmr_e   next_state;
  logic [9:0] pre;
  logic [7:0] steps;
  logic       step_end;

  assign step_end = (pre == STEP_LAST);

  always_comb begin
    next_state = state;
    case (state)
      TMR_IDLE: begin
        if (active_i) next_state = TMR_ACTIVE;
      end
      TMR_ACTIVE: begin
        if (!active_i) next_state = (count_i == STEPS_NONE) ? TMR_IDLE : TMR_HOLD;
      end
      TMR_HOLD: begin
        if (active_i) next_state = TMR_ACTIVE;
        else if (step_end && steps == STEP_ONE) next_state = TMR_IDLE;
      end
      default: next_state = TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) state <= TMR_IDLE;
    else state <= next_state;
  end

  // the step count is captured when activity ends, so a rewrite mid-hold waits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre   <= PRE_ZERO;
      steps <= STEPS_NONE;
    end else if (state != TMR_HOLD) begin
      pre   <= PRE_ZERO;
      steps <= count_i;
    end else if (step_end) begin
      pre   <= PRE_ZERO;
      steps <= steps - STEP_ONE;
    end else begin
      pre   <= pre + PRE_ONE;
    end
  end

  // registered state only, which keeps the two cross-coupled timers loop free
  assign blank_o = (state != TMR_IDLE);

endmodule

// ===== test/ssp_ir_xcvr.sv
// ssp_ir_xcvr: infrared transceiver stand-in that drives both receive pins
// assumes the bench picks the live pin pair and its level
module ssp_ir_xcvr (
  input  wire logic clk_i,
  input  wire logic level_i,
  input  wire logic alt_i,
  output logic      rx_o,
  output logic      alt_rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic chatter = 1'b0;
  // the pin that is not live toggles, so a wrong route cannot pass by luck
  always @(posedge clk_i) chatter <= ~chatter;
  assign rx_o     = alt_i ? chatter : level_i;
  assign alt_rx_o = alt_i ? level_i : chatter;
endmodule

// ===== test/ssp_ir_config_sva.sv
// ssp_ir_config_sva: port-level checks of the second serial port config block
// assumes it is bound to ssp_ir_config and sees only its ports
module ssp_ir_config_sva
  import ssp_pkg::*;
(
  input wire logic       MCLK_I,
  input wire logic       NRST_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_WDATA_I,
  input wire logic       CFG_WR_I,
  input wire logic       CFG_RD_I,
  input wire logic [7:0] CFG_RDATA_O,
  input wire logic       UART_TX_I,
  input wire logic       UART_RX_O,
  input wire logic       SECOND_PORT_RECEIVE_PIN_I,
  input wire logic       SECOND_PORT_TRANSMIT_PIN_O,
  input wire logic       ALTERNATE_INFRARED_TRANSMIT_PIN_O,
  input wire logic       MIDI_EN_O,
  input wire logic       HIGH_SPEED_O,
  input wire logic [2:0] IR_ENCODING_O,
  input wire logic       HALF_DUPLEX_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  logic wr0, wr1, wr2;
  assign wr0 = CFG_WR_I && CFG_ADDR_I == IDX_PORT_MODE;
  assign wr1 = CFG_WR_I && CFG_ADDR_I == IDX_IR_OPTION;
  assign wr2 = CFG_WR_I && CFG_ADDR_I == IDX_HD_TIMEOUT;
  // irda, full duplex, normal pins: polarity is live
  sequence ir_wr;
    wr1 && CFG_WDATA_I[6:2] == 5'h02;
  endsequence
  sequence std_wr;
    wr1 && CFG_WDATA_I[6:2] == 5'h00;
  endsequence
  sequence tmo_wr_rd;
    wr2 ##1 (CFG_RD_I && CFG_ADDR_I == IDX_HD_TIMEOUT);
  endsequence
  midi_follow_a: assert property (wr0 |=> MIDI_EN_O == $past(CFG_WDATA_I[0]))
    else $error("midi flag does not follow write");
  speed_follow_a: assert property (wr0 |=> HIGH_SPEED_O == $past(CFG_WDATA_I[1]))
    else $error("high speed flag does not follow write");
  duplex_follow_a: assert property (wr1 |-> ##2 HALF_DUPLEX_O == $past(CFG_WDATA_I[2], 2))
    else $error("duplex output does not follow write");
  enc_follow_a: assert property ((wr1 && !CFG_WDATA_I[5] && CFG_WDATA_I[4:3] != 2'h3)
    |-> ##2 IR_ENCODING_O == $past(CFG_WDATA_I[5:3], 2)) else $error("encoding wrong");
  enc_reserved_a: assert property ((wr1 && (CFG_WDATA_I[5] || CFG_WDATA_I[4:3] == 2'h3))
    |-> ##2 IR_ENCODING_O == ENC_STANDARD) else $error("reserved encoding not standard");
  reserved_zero_a: assert property ((CFG_RD_I && CFG_ADDR_I == IDX_PORT_MODE)
    |=> CFG_RDATA_O[7:2] == 6'h00) else $error("reserved mode bits read nonzero");
  timeout_back_a: assert property (tmo_wr_rd |=> CFG_RDATA_O == $past(CFG_WDATA_I, 2))
    else $error("timeout readback wrong");
  // the unused pin rests at the idle level after polarity, low for active-high infrared
  alt_idle_a: assert property ((wr1 && !CFG_WDATA_I[6])
    |-> ##2 ALTERNATE_INFRARED_TRANSMIT_PIN_O == (LINE_IDLE ^
      (($past(CFG_WDATA_I[5:3], 2) == ENC_IRDA || $past(CFG_WDATA_I[5:3], 2) == ENC_ASK)
      && !$past(CFG_WDATA_I[1], 2)))) else $error("alt pin not idle");
  rdata_idle_a: assert property (!CFG_RD_I |=> CFG_RDATA_O == READ_NONE)
    else $error("read data outside read window");
  tx_polarity_a: assert property (ir_wr |-> ##2 SECOND_PORT_TRANSMIT_PIN_O
    == ($past(UART_TX_I) ^ !$past(CFG_WDATA_I[1], 2))) else $error("tx polarity wrong");
  rx_polarity_a: assert property (ir_wr |-> ##2 UART_RX_O
    == ($past(SECOND_PORT_RECEIVE_PIN_I) ^ !$past(CFG_WDATA_I[0], 2))) else $error("rx polarity");
  std_pass_a: assert property (std_wr |-> ##2 SECOND_PORT_TRANSMIT_PIN_O == $past(UART_TX_I))
    else $error("standard mode not pass-through");
endmodule
bind ssp_ir_config ssp_ir_config_sva chk (.*);

// ===== test/testbench.sv
// testbench: drives the config port and line pins of ssp_ir_config, checks ports
// assumes the transceiver model on the receive pins and the bound checker
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ssp_pkg::*;
  logic       MCLK_I = 1'b0, NRST_I = 1'b0, CFG_WR_I = 1'b0, CFG_RD_I = 1'b0;
  logic [7:0] CFG_ADDR_I = 8'h00, CFG_WDATA_I = 8'h00, t;
  logic       UART_TX_I = 1'b1, lvl = 1'b1, alt = 1'b0, rd_seen = 1'b0, tv, rv, ir;
  logic [7:0] CFG_RDATA_O;
  logic [2:0] IR_ENCODING_O, e;
  logic [1:0] p;
  logic       UART_RX_O, SECOND_PORT_TRANSMIT_PIN_O, ALTERNATE_INFRARED_TRANSMIT_PIN_O;
  logic       MIDI_EN_O, HIGH_SPEED_O, HALF_DUPLEX_O;
  logic       SECOND_PORT_RECEIVE_PIN_I, ALTERNATE_INFRARED_RECEIVE_PIN_I;
  logic [7:0] exp_q[$];
  int         fail_count = 0, checks = 0, i, n, seed;
  ssp_ir_config dut (.*);
  ssp_ir_xcvr xcvr (.clk_i(MCLK_I), .level_i(lvl), .alt_i(alt),
    .rx_o(SECOND_PORT_RECEIVE_PIN_I), .alt_rx_o(ALTERNATE_INFRARED_RECEIVE_PIN_I));
  always #50 MCLK_I = ~MCLK_I;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one bus cycle per call, so strobes never get two assignments in one step
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK_I);
    CFG_WR_I <= w;
    CFG_RD_I <= r;
    CFG_ADDR_I <= a;
    CFG_WDATA_I <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle();
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  always @(posedge MCLK_I) begin
    if (rd_seen) chk(CFG_RDATA_O, exp_q.pop_front());
    rd_seen <= CFG_RD_I;
  end
  initial begin
    seed = $urandom(90075);
    repeat (4) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    rd(IDX_PORT_MODE, RST_PORT_MODE);
    rd(IDX_IR_OPTION, RST_IR_OPTION);
    rd(IDX_HD_TIMEOUT, RST_HD_TIMEOUT);
    rd(8'h10, READ_NONE);
    for (i = 0; i < 4; i++) begin
      wr(IDX_PORT_MODE, 8'(i));
      rd(IDX_PORT_MODE, 8'(i));
      #1;
      chk(8'(MIDI_EN_O), 8'(i % 2));
      chk(8'(HIGH_SPEED_O), 8'(i / 2));
      t = 8'($urandom);
      wr(IDX_HD_TIMEOUT, t);
      rd(IDX_HD_TIMEOUT, t);
    end
    for (i = 0; i < 32; i++) begin
      e = 3'(i / 4);
      p = 2'(i);
      ir = (e == ENC_IRDA || e == ENC_ASK);
      tv = 1'($urandom);
      rv = 1'($urandom);
      wr(IDX_IR_OPTION, {2'b00, e, 1'b0, p});
      idle();
      UART_TX_I <= tv;
      lvl <= rv;
      idle();
      #1;
      chk(8'(SECOND_PORT_TRANSMIT_PIN_O), 8'(tv ^ (ir & ~p[1])));
      chk(8'(UART_RX_O), 8'(rv ^ (ir & ~p[0])));
      chk(8'(ALTERNATE_INFRARED_TRANSMIT_PIN_O), 8'(LINE_IDLE ^ (ir & ~p[1])));
      chk(8'(IR_ENCODING_O), 8'(e <= ENC_ASK ? e : ENC_STANDARD));
      chk(8'(HALF_DUPLEX_O), 8'h00);
    end
    wr(IDX_IR_OPTION, 8'h40);
    alt <= 1'b1;
    idle();
    UART_TX_I <= 1'b0;
    lvl <= 1'b0;
    idle();
    #1;
    chk({ALTERNATE_INFRARED_TRANSMIT_PIN_O, SECOND_PORT_TRANSMIT_PIN_O, UART_RX_O}, 8'h02);
    for (i = 0; i < 2; i++) begin
      // receive goes quiet before the count changes, else its window holds transmit off
      lvl <= 1'b1;
      wr(IDX_HD_TIMEOUT, 8'(i));
      wr(IDX_IR_OPTION, 8'h04);
      alt <= 1'b0;
      lvl <= 1'b1;
      UART_TX_I <= 1'b1;
      repeat (4) idle();
      UART_TX_I <= 1'b0;
      repeat (3) idle();
      UART_TX_I <= 1'b1;
      lvl <= 1'b0;
      #1;
      chk(8'(HALF_DUPLEX_O), 8'h01);
      // receive stays blanked for count steps of 1000 cycles after transmit ends
      for (n = 0; n < 1100; n++) begin
        idle();
        #1;
        if (UART_RX_O === 1'b0) break;
      end
      if (n >= 1100) begin
        fail_count++;
        complete_run();
      end
      chk(8'(n >= 1000 * i && n <= 1000 * i + 4), 8'h01);
    end
    NRST_I <= 1'b0;
    idle();
    NRST_I <= 1'b1;
    rd(IDX_IR_OPTION, RST_IR_OPTION);
    repeat (3) idle();
    complete_run();
  end
endmodule
